// [src/cti_defines.vh]
// constants for the conversion timing and digital i/o block
`ifndef CTI_DEFINES_VH
`define CTI_DEFINES_VH
`define CTI_CLK_HZ 125000000
`define CTI_TB_HZ 1000000
`define CTI_TB_DIV (`CTI_CLK_HZ / `CTI_TB_HZ)
`define CTI_TB_HALF (`CTI_TB_DIV / 2)
`define CTI_CONV_LIMIT_US 20
// divide first: the product would overflow a 32-bit integer
`define CTI_CONV_LIMIT_CYC (`CTI_CONV_LIMIT_US * (`CTI_CLK_HZ / 1000000))
`define CTI_CNT_W 16
`define CTI_FIFO_DEPTH 16
`define CTI_FIFO_AW 4
`define CTI_DIO_W 4
`define CTI_GATE_LEVEL 1'b0
`define CTI_GATE_EDGE 1'b1
`define CTI_EDGE_RISE 1'b0
`define CTI_EDGE_FALL 1'b1
`define CTI_CNT_RESET 16'h0000
`define CTI_SAMPLE_RESET 16'h0002
// sized forms of the counts above for compares; keep them in step by hand
`define CTI_TB_LAST 8'h7c
`define CTI_TB_HIGH 8'h3e
`define CTI_CONV_LAST 12'h9c3
`define CTI_FIFO_FULL 5'h10
`endif

// [src/cti_conversion_timing_io.v]
// conversion timing, general purpose counters, sample fifo and digital i/o
//
// Overview of operation
// - counter 0 is the sample-interval timer and none of its signals leave the block.
// - each rising edge of the external convert pin starts exactly one conversion; here only while ext_convert_enable_in is high.
// - an externally started conversion must land in the sample fifo within 20 us.
// - the external convert pin is input only and never shows timer-paced conversions.
// - counter 0 counts the internal 1 MHz timebase with its gate always enabled; here it counts only while sample_enable_in is high.
// - counter a has its gate always enabled and only its clock and output reach pins.
// - counter b has gate, clock and output all on pins.
// - a continuous 1 MHz square wave is driven on a dedicated output.
// - a general purpose counter counts selected rising or falling clock edges while gated.
// - in level-gated mode counter b decrements only while its gate is high.
// - in edge-gated mode counter b starts counting after a rising gate edge.
// - one dedicated input port and one dedicated output port, no direction control.
// - a conversion starts on a rising edge of the timer output or the external pin.
// - counter 0 is a 16-bit down counter that pulses low and reloads at one until reprogrammed.
// - the fifo holds 16 results; a write when full with no read in the same cycle loses data and flags overflow.
`timescale 1ns/100ps
`include "cti_defines.vh"

module cti_conversion_timing_io
(
	// clock, reset, enable
	input wire clk_in,
	input wire resetn_in,
	input wire ce_in,
	// connector pins
	input wire ext_convert_n_in,
	input wire gp_counter_a_clk_in,
	input wire gp_counter_b_gate_in,
	input wire gp_counter_b_clk_in,
	input wire [`CTI_DIO_W-1:0] din_in,
	output wire gp_counter_a_out_out,
	output wire gp_counter_b_out_out,
	output wire timebase_1mhz_out,
	output wire [`CTI_DIO_W-1:0] dout_out,
	// sample timer control
	input wire [`CTI_CNT_W-1:0] sample_count_in,
	input wire sample_load_in,
	input wire sample_enable_in,
	input wire ext_convert_enable_in,
	// general purpose counters, index 0 is counter a, index 1 is counter b
	input wire [2*`CTI_CNT_W-1:0] gp_load_value_in,
	input wire [1:0] gp_load_in,
	input wire [1:0] gp_edge_sel_in,
	input wire [1:0] gp_gate_mode_in,
	input wire [1:0] gp_latch_in,
	output wire [2*`CTI_CNT_W-1:0] gp_latched_count_out,
	// digital i/o, logic side
	input wire [`CTI_DIO_W-1:0] dout_data_in,
	input wire dout_write_in,
	output wire [`CTI_DIO_W-1:0] din_data_out,
	// converter interface
	output wire conv_start_out,
	input wire [`CTI_CNT_W-1:0] adc_result_in,
	input wire adc_valid_in,
	// sample fifo
	input wire fifo_read_in,
	output wire [`CTI_CNT_W-1:0] fifo_data_out,
	output wire fifo_empty_out,
	output wire fifo_overflow_out,
	input wire fifo_overflow_clear_in,
	output wire conv_late_out
);

	// timebase divider
	reg [7:0] tb_cnt_reg;
	reg tb_out_reg;
	wire tb_tick;
	assign tb_tick = (tb_cnt_reg == `CTI_TB_LAST);
	// 125 is odd, so the high half is one cycle shorter than the low half
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			tb_cnt_reg <= 8'h00;
			tb_out_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			tb_cnt_reg <= tb_tick ? 8'h00 : tb_cnt_reg + 8'h01;
			tb_out_reg <= (tb_cnt_reg < `CTI_TB_HIGH);
		end
	end
	assign timebase_1mhz_out = tb_out_reg;

	// pin synchronisers: first stage is read only by the second
	localparam SYNC_W = 4 + `CTI_DIO_W;
	wire [SYNC_W-1:0] pin_raw;
	reg [SYNC_W-1:0] sync1_reg;
	reg [SYNC_W-1:0] sync2_reg;
	reg [SYNC_W-1:0] sync3_reg;
	assign pin_raw = {din_in, gp_counter_b_gate_in, gp_counter_b_clk_in,
		gp_counter_a_clk_in, ext_convert_n_in};
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sync1_reg <= {SYNC_W{1'b1}};
			sync2_reg <= {SYNC_W{1'b1}};
			sync3_reg <= {SYNC_W{1'b1}};
		end
		else if (ce_in)
		begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	wire ext_rise;
	assign ext_rise = sync2_reg[0] & ~sync3_reg[0];
	assign din_data_out = sync2_reg[SYNC_W-1:4];

	// sample-interval timer, internal only
	reg [`CTI_CNT_W-1:0] st_reload_reg;
	reg [`CTI_CNT_W-1:0] st_count_reg;
	reg st_out_reg;
	reg st_out_d_reg;
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_reload_reg <= `CTI_SAMPLE_RESET;
			st_count_reg <= `CTI_SAMPLE_RESET;
			st_out_reg <= 1'b1;
			st_out_d_reg <= 1'b1;
		end
		else if (ce_in)
		begin
			st_out_d_reg <= st_out_reg;
			if (sample_load_in)
			begin
				st_reload_reg <= sample_count_in;
				st_count_reg <= sample_count_in;
				st_out_reg <= 1'b1;
			end
			else if (tb_tick && sample_enable_in)
			begin
				// low for one tick from the reload, so the first decrement after it is a rising edge
				if (st_count_reg == 16'h0001)
				begin
					st_count_reg <= st_reload_reg;
					st_out_reg <= 1'b0;
				end
				else
				begin
					st_count_reg <= st_count_reg - 16'h0001;
					st_out_reg <= 1'b1;
				end
			end
		end
	end
	wire st_rise;
	assign st_rise = st_out_reg & ~st_out_d_reg;

	// conversion start: timer rise or external rise; the pin is never driven
	reg conv_start_reg;
	reg ext_pending_reg;
	reg [11:0] late_cnt_reg;
	reg conv_late_reg;
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			conv_start_reg <= 1'b0;
			ext_pending_reg <= 1'b0;
			late_cnt_reg <= 12'h000;
			conv_late_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			conv_start_reg <= st_rise | (ext_rise & ext_convert_enable_in);
			if (ext_rise && ext_convert_enable_in)
			begin
				ext_pending_reg <= 1'b1;
				late_cnt_reg <= 12'h000;
			end
			else if (adc_valid_in)
				ext_pending_reg <= 1'b0;
			else if (ext_pending_reg)
			begin
				// no converter result (adc_valid_in) within the limit after the edge
				if (late_cnt_reg == `CTI_CONV_LAST)
				begin
					conv_late_reg <= 1'b1;
					ext_pending_reg <= 1'b0;
				end
				late_cnt_reg <= late_cnt_reg + 12'h001;
			end
		end
	end
	assign conv_start_out = conv_start_reg;
	assign conv_late_out = conv_late_reg;

	// sample fifo
	reg [`CTI_CNT_W-1:0] fifo_mem [0:`CTI_FIFO_DEPTH-1];
	reg [`CTI_FIFO_AW-1:0] wr_ptr_reg;
	reg [`CTI_FIFO_AW-1:0] rd_ptr_reg;
	reg [`CTI_FIFO_AW:0] level_reg;
	reg [`CTI_CNT_W-1:0] fifo_data_reg;
	reg overflow_reg;
	wire fifo_full;
	wire do_wr;
	wire do_rd;
	assign fifo_full = (level_reg == `CTI_FIFO_FULL);
	assign fifo_empty_out = (level_reg == 5'h00);
	assign do_rd = fifo_read_in & ~fifo_empty_out;
	assign do_wr = adc_valid_in & (~fifo_full | do_rd);
	always @(posedge clk_in)
	begin
		if (ce_in && do_wr)
			fifo_mem[wr_ptr_reg] <= adc_result_in;
	end
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wr_ptr_reg <= 4'h0;
			rd_ptr_reg <= 4'h0;
			level_reg <= 5'h00;
			fifo_data_reg <= 16'h0000;
			overflow_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			if (do_wr)
				wr_ptr_reg <= wr_ptr_reg + 4'h1;
			if (do_rd)
			begin
				fifo_data_reg <= fifo_mem[rd_ptr_reg];
				rd_ptr_reg <= rd_ptr_reg + 4'h1;
			end
			if (do_wr != do_rd)
				level_reg <= do_wr ? level_reg + 5'h01 : level_reg - 5'h01;
			// set beats clear: a lost sample in the clear cycle stays flagged
			if (adc_valid_in && !do_wr)
				overflow_reg <= 1'b1;
			else if (fifo_overflow_clear_in)
				overflow_reg <= 1'b0;
		end
	end
	assign fifo_data_out = fifo_data_reg;
	assign fifo_overflow_out = overflow_reg;

	// digital output port
	reg [`CTI_DIO_W-1:0] dout_reg;
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			dout_reg <= 4'h0;
		else if (ce_in && dout_write_in)
			dout_reg <= dout_data_in;
	end
	assign dout_out = dout_reg;

	// general purpose counters
	wire [1:0] gp_out;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gp
			reg [`CTI_CNT_W-1:0] count_reg;
			reg [`CTI_CNT_W-1:0] latch_reg;
			reg out_reg;
			reg armed_reg;
			reg gate_d_reg;
			wire clk_now;
			wire clk_old;
			wire gate_now;
			wire edge_hit;
			wire gate_rise;
			wire run;
			assign clk_now = sync2_reg[1+g];
			assign clk_old = sync3_reg[1+g];
			// counter a gate is tied on; counter b gate comes from its pin
			assign gate_now = (g == 0) ? 1'b1 : sync2_reg[3];
			assign edge_hit = (gp_edge_sel_in[g] == `CTI_EDGE_RISE) ?
				(clk_now & ~clk_old) : (~clk_now & clk_old);
			assign gate_rise = gate_now & ~gate_d_reg;
			assign run = (gp_gate_mode_in[g] == `CTI_GATE_LEVEL) ? gate_now : armed_reg;
			always @(posedge clk_in or negedge resetn_in)
			begin
				if (!resetn_in)
				begin
					count_reg <= `CTI_CNT_RESET;
					latch_reg <= `CTI_CNT_RESET;
					out_reg <= 1'b0;
					armed_reg <= 1'b0;
					// gate pin idles high on its pull-up: no false gate edge after reset
					gate_d_reg <= 1'b1;
				end
				else if (ce_in)
				begin
					gate_d_reg <= gate_now;
					if (gp_latch_in[g])
						latch_reg <= count_reg;
					if (gp_load_in[g])
					begin
						count_reg <= gp_load_value_in[g*16 +: 16];
						out_reg <= 1'b0;
						armed_reg <= 1'b0;
					end
					else
					begin
						if (gate_rise)
							armed_reg <= 1'b1;
						if (edge_hit && run)
						begin
							count_reg <= count_reg - 16'h0001;
							if (count_reg == 16'h0001)
								out_reg <= 1'b1;
						end
					end
				end
			end
			assign gp_out[g] = out_reg;
			assign gp_latched_count_out[g*16 +: 16] = latch_reg;
		end
	endgenerate
	assign gp_counter_a_out_out = gp_out[0];
	assign gp_counter_b_out_out = gp_out[1];

endmodule

// [test/cti_timing_monitor.sv]
// port assertions for the conversion timing block
`timescale 1ns/100ps
`include "cti_defines.vh"
module cti_timing_monitor
(
	// watched ports
	input wire clk_in,
	input wire resetn_in,
	input wire ce_in,
	input wire ext_convert_n_in,
	input wire ext_convert_enable_in,
	input wire sample_enable_in,
	input wire timebase_1mhz_out,
	input wire [`CTI_DIO_W-1:0] dout_out,
	input wire [`CTI_DIO_W-1:0] dout_data_in,
	input wire dout_write_in,
	input wire conv_start_out,
	input wire fifo_overflow_out,
	input wire fifo_overflow_clear_in,
	input wire fifo_empty_out,
	input wire fifo_read_in,
	input wire [`CTI_CNT_W-1:0] fifo_data_out,
	input wire conv_late_out,
	input wire gp_counter_b_out_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_ext_start_lat: assert property (ce_in && ext_convert_enable_in
		&& $rose(ext_convert_n_in) |-> ##[3:5] conv_start_out) else $error("ext start late");
	a_start_one_cyc: assert property (conv_start_out |=> !conv_start_out)
		else $error("start not one cycle");
	a_tbase_high: assert property ($rose(timebase_1mhz_out) |-> ##62 $fell(timebase_1mhz_out))
		else $error("timebase high time");
	a_tbase_low: assert property ($fell(timebase_1mhz_out) |-> ##63 $rose(timebase_1mhz_out))
		else $error("timebase low time");
	a_dout_write: assert property (dout_write_in && ce_in |=> dout_out == $past(dout_data_in))
		else $error("dout not written");
	a_ovf_sticky: assert property (fifo_overflow_out && !fifo_overflow_clear_in
		|=> fifo_overflow_out) else $error("overflow lost");
	a_empty_read: assert property (fifo_empty_out && fifo_read_in |=> $stable(fifo_data_out))
		else $error("read of empty fifo");
	a_late_hold: assert property (conv_late_out |=> conv_late_out)
		else $error("late flag dropped");
	a_no_source: assert property ((!ext_convert_enable_in && !sample_enable_in)[*6]
		|-> !conv_start_out) else $error("start without source");
	cover property (conv_start_out);
	cover property ($rose(fifo_overflow_out));
	cover property ($rose(gp_counter_b_out_out));
endmodule
bind cti_conversion_timing_io cti_timing_monitor u_cti_timing_monitor (.clk_in, .resetn_in,
	.ce_in, .ext_convert_n_in, .ext_convert_enable_in, .sample_enable_in, .timebase_1mhz_out,
	.dout_out, .dout_data_in, .dout_write_in, .conv_start_out, .fifo_overflow_out,
	.fifo_overflow_clear_in, .fifo_empty_out, .fifo_read_in, .fifo_data_out, .conv_late_out,
	.gp_counter_b_out_out);

// [test/cti_adc_model.sv]
// converter model: answers each start with a counting result after a delay while mute_in is low
`timescale 1ns/100ps
module cti_adc_model #(parameter DELAY = 20)
(
	// control
	input wire clk_in,
	input wire resetn_in,
	input wire conv_start_in,
	input wire mute_in,
	// result
	output reg [15:0] result_out,
	output reg valid_out
);
	integer wait_reg;
	// answers well inside the 20 us limit; mute_in withholds answers to reach the late flag
	always @(posedge clk_in or negedge resetn_in)
		if (!resetn_in)
		begin
			wait_reg <= 0;
			result_out <= 16'h1000;
			valid_out <= 1'b0;
		end
		else
		begin
			valid_out <= (wait_reg == 1) && !mute_in;
			if (conv_start_in)
				wait_reg <= DELAY;
			else if (wait_reg != 0)
				wait_reg <= wait_reg - 1;
			if (wait_reg == 1)
				result_out <= result_out + 16'h0001;
		end
endmodule

// [test/tb_top.sv]
// self-checking bench for the conversion timing block
`timescale 1ns/100ps
`include "cti_defines.vh"
module tb_top;
	reg clk_in = 1'b0;
	reg resetn_in = 1'b0;
	reg ext_n = 1'b1;
	reg ext_en = 1'b0;
	reg a_clk = 1'b0;
	reg b_gate = 1'b0;
	reg b_clk = 1'b0;
	reg [3:0] din = 4'h0;
	reg [15:0] scount = 16'h0000;
	reg sload = 1'b0;
	reg sen = 1'b0;
	reg [31:0] gp_val = 32'h0;
	reg [1:0] gp_load = 2'h0;
	reg [1:0] gp_sel = 2'h1;
	reg [1:0] gp_mode = 2'h0;
	reg [1:0] gp_latch = 2'h0;
	reg [3:0] dout_d = 4'h0;
	reg dout_w = 1'b0;
	reg rd = 1'b0;
	reg ovf_clr = 1'b0;
	reg mute = 1'b0;
	wire a_out, b_out, start, adc_v, empty, ovf, late, tbase;
	wire [3:0] dout, din_q;
	wire [31:0] latched;
	wire [15:0] adc_d, fdata;
	integer errors = 0;
	integer total_checks = 0;
	integer n;
	integer i;
	always #4 clk_in = ~clk_in;
	cti_conversion_timing_io u_cti_conversion_timing_io (.clk_in(clk_in), .resetn_in(resetn_in),
		.ce_in(1'b1), .ext_convert_n_in(ext_n), .gp_counter_a_clk_in(a_clk),
		.gp_counter_b_gate_in(b_gate), .gp_counter_b_clk_in(b_clk), .din_in(din),
		.gp_counter_a_out_out(a_out), .gp_counter_b_out_out(b_out), .timebase_1mhz_out(tbase),
		.dout_out(dout), .sample_count_in(scount), .sample_load_in(sload),
		.sample_enable_in(sen), .ext_convert_enable_in(ext_en), .gp_load_value_in(gp_val),
		.gp_load_in(gp_load), .gp_edge_sel_in(gp_sel), .gp_gate_mode_in(gp_mode),
		.gp_latch_in(gp_latch), .gp_latched_count_out(latched), .dout_data_in(dout_d),
		.dout_write_in(dout_w), .din_data_out(din_q), .conv_start_out(start),
		.adc_result_in(adc_d), .adc_valid_in(adc_v), .fifo_read_in(rd), .fifo_data_out(fdata),
		.fifo_empty_out(empty), .fifo_overflow_out(ovf), .fifo_overflow_clear_in(ovf_clr),
		.conv_late_out(late));
	cti_adc_model u_cti_adc_model (.clk_in(clk_in), .resetn_in(resetn_in),
		.conv_start_in(start), .mute_in(mute), .result_out(adc_d), .valid_out(adc_v));
	task stop_test;
		begin
			if (errors == 0 && total_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp)
			begin
				errors = errors + 1;
				$display("[ERR] %0s expected %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge clk_in);
	endtask
	// bounded wait for a start pulse; n counts edges waited
	task wait_start(input integer lim, input must);
		begin
			n = 0;
			do
			begin
				@(posedge clk_in);
				#1;
				n = n + 1;
			end
			while (start !== 1'b1 && n < lim);
			if (must && start !== 1'b1)
			begin
				chk(0, 1, "start");
				stop_test;
			end
		end
	endtask
	task ext_edge;
		begin
			cyc(1);
			ext_n <= 1'b0;
			cyc(4);
			ext_n <= 1'b1;
		end
	endtask
	// pin clocks kept slow, far below the sync limit
	task clks(input integer k);
		repeat (k)
		begin
			cyc(8);
			a_clk <= 1'b1;
			b_clk <= 1'b1;
			cyc(8);
			a_clk <= 1'b0;
			b_clk <= 1'b0;
		end
	endtask
	task latch;
		begin
			cyc(6);
			gp_latch <= 2'b11;
			cyc(1);
			gp_latch <= 2'b00;
			cyc(3);
			#1;
		end
	endtask
	task gload(input [31:0] v);
		begin
			cyc(1);
			gp_val <= v;
			gp_load <= 2'b11;
			cyc(1);
			gp_load <= 2'b00;
		end
	endtask
	task pop(input [15:0] e);
		begin
			cyc(1);
			rd <= 1'b1;
			cyc(1);
			rd <= 1'b0;
			#1;
			chk(fdata, e, "fifo");
		end
	endtask
	task t_dio;
		begin
			cyc(1);
			din <= 4'ha;
			dout_d <= 4'h5;
			dout_w <= 1'b1;
			cyc(1);
			dout_w <= 1'b0;
			cyc(4);
			#1;
			chk(dout, 4'h5, "dout");
			chk(din_q, 4'ha, "din");
		end
	endtask
	// n counts edges while the timebase stays at lvl; bounded so a stuck pin ends the wait
	task run_len(input lvl);
		begin
			n = 0;
			while (tbase === lvl && n < 200)
			begin
				@(posedge clk_in);
				#1;
				n = n + 1;
			end
		end
	endtask
	task t_tbase;
		begin
			run_len(1'b1);
			run_len(1'b0);
			run_len(1'b1);
			chk(n, `CTI_TB_HALF, "tb_high");
			run_len(1'b0);
			chk(n, `CTI_TB_DIV - `CTI_TB_HALF, "tb_low");
		end
	endtask
	task t_gp;
		begin
			gload(32'h0003_0002);
			clks(2);
			latch;
			chk(a_out, 1, "a_out");
			chk(latched, 32'h0003_0000, "latch");
			cyc(1);
			b_gate <= 1'b1;
			clks(2);
			latch;
			chk(latched[31:16], 1, "b_cnt");
			chk(b_out, 0, "b_out");
			clks(1);
			latch;
			chk(b_out, 1, "b_out");
			cyc(1);
			gp_mode <= 2'b10;
			gload(32'h0002_0002);
			clks(1);
			latch;
			chk(latched[31:16], 2, "b_arm");
			cyc(1);
			b_gate <= 1'b0;
			cyc(2);
			b_gate <= 1'b1;
			clks(2);
			latch;
			chk(b_out, 1, "b_edge");
		end
	endtask
	task t_ext;
		begin
			cyc(1);
			ext_en <= 1'b1;
			ext_edge;
			wait_start(8, 1);
			chk(n >= 3 && n <= 5, 1, "ext_lat");
			cyc(30);
			pop(16'h1001);
			cyc(2600);
			chk(late, 0, "late");
			ext_en <= 1'b0;
			ext_edge;
			wait_start(12, 0);
			chk(start, 0, "ext_off");
		end
	endtask
	task t_fifo;
		begin
			cyc(1);
			ext_en <= 1'b1;
			for (i = 0; i < 17; i = i + 1)
			begin
				ext_edge;
				cyc(30);
			end
			chk(ovf, 1, "ovf");
			ovf_clr <= 1'b1;
			cyc(1);
			ovf_clr <= 1'b0;
			cyc(1);
			#1;
			chk(ovf, 0, "ovf_clr");
			for (i = 0; i < 16; i = i + 1)
				pop(16'h1002 + i[15:0]);
			chk(empty, 1, "empty");
			pop(16'h1011);
		end
	endtask
	// the muted converter never answers, so the late flag must rise just past the limit
	task t_late;
		begin
			cyc(1);
			ext_en <= 1'b1;
			mute <= 1'b1;
			ext_edge;
			cyc(`CTI_CONV_LIMIT_CYC - 10);
			#1;
			chk(late, 0, "late_lo");
			cyc(20);
			#1;
			chk(late, 1, "late_hi");
			cyc(1);
			mute <= 1'b0;
			ext_en <= 1'b0;
		end
	endtask
	task t_timer;
		begin
			cyc(1);
			ext_en <= 1'b0;
			scount <= 16'h0002;
			sload <= 1'b1;
			cyc(1);
			sload <= 1'b0;
			sen <= 1'b1;
			wait_start(600, 1);
			wait_start(400, 1);
			chk(n, 2 * `CTI_TB_DIV, "period");
		end
	endtask
	initial
	begin
		cyc(6);
		resetn_in <= 1'b1;
		t_dio;
		t_tbase;
		t_gp;
		t_ext;
		t_fifo;
		t_late;
		t_timer;
		stop_test;
	end
endmodule
